// ---- pkg/string_ops_pkg.sv ----
package string_ops_pkg;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 18;
  localparam logic [15:0] ERR_CODE = 16'h1A32;
  localparam logic [LEN_W-1:0] LEN_LIMIT = 18'h08000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] NULL_WORD = 16'h0000;
  localparam int LIT_MAX_CHARS = 32;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    op_join,
    byte_count_op,
    tail_extract_op
  } op_kind_t;

  typedef struct packed {
    op_kind_t    op;
    logic        pulse;
    logic [15:0] first_source_head;
    logic [15:0] second_source_head;
    logic [15:0] dest_head;
    logic [15:0] dest_words;
    logic [15:0] source_end;
    logic [15:0] count;
  } instr_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
endpackage

// ---- core/string_engine.sv ----
// Operation
// - Join writes second string after first at destination.
// - Source string ends before first zero byte.
// - First terminator dropped; second string follows directly.
// - Zero terminator appended after joined string.
// - Odd joined count: terminator in high byte.
// - Even joined count: zero word follows.
// - Error sets flag and stores error code.
// - Join errors when destination too small.
// - Join errors when operand heads coincide.
// - Missing terminator within source range errors.
// - Byte count written as 16-bit binary.
// - Count is in bytes, not characters.
// - Byte count at or above limit errors.
// - Tail extract copies last n bytes.
// - Zero count writes a null word.
// - Terminator appended after extracted bytes.
// - Odd extract: high byte; even: zero word.
// - Two bytes per word, first in low byte.
// - Negative or oversized extract count errors.
// - Continuous runs each scan; pulse once per rise.
`timescale 1ns/1ps

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = fill != (PW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data  = store[rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      store[wptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == PW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == PW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // byte_fifo

module string_engine
  import string_ops_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  string_ops_pkg::instr_t        instr,
  input  wire logic                     scan_strobe,
  input  wire logic                     cond,
  output string_ops_pkg::mem_req_t      mem_req,
  input  wire logic [15:0]              mem_rdata,
  input  wire logic                     error_flag_clear,
  output logic                          busy,
  output logic                          done,
  output logic                          operation_error_flag,
  output logic [15:0]                   error_code_word
);
  import string_ops_pkg::*;
  typedef enum logic [2:0] {st_idle, st_scan, st_check, st_len_wr, st_copy, st_term, st_done} state_t;
  state_t           state;
  instr_t           q;
  logic             prev_cond;
  logic             start;
  logic [16:0]      scan_addr;
  logic             scan_second;
  logic [1:0]       phase;
  logic [LEN_W-1:0] len1;
  logic [LEN_W-1:0] len2;
  logic [LEN_W-1:0] out_len;
  logic             err_set;
  logic             chk_err;
  logic [15:0]      rd_base;
  logic [LEN_W-1:0] rd_idx;
  logic [LEN_W-1:0] rd_left;
  logic             rd_seg;
  logic             hold_v;
  logic [7:0]       hold_b;
  logic             f_in_ready;
  logic             f_out_valid;
  logic [7:0]       f_out_data;
  logic             f_out_ready;
  logic             have_lo;
  logic [7:0]       lo_byte;
  logic             wr_pend;
  logic [15:0]      wr_word;
  logic [15:0]      wr_addr;
  logic [LEN_W-1:0] popped;
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction
  function automatic logic [LEN_W-1:0] words_needed(input logic [LEN_W-1:0] n);
    return (n >> 1) + 1'b1;
  endfunction
  // A scan that arrives while busy is dropped; the sequencer re-issues it next scan.
  assign start = scan_strobe && cond && (!instr.pulse || !prev_cond) && state == st_idle;
  always_comb begin
    chk_err = 1'b0;
    case (q.op)
      op_join: begin
        chk_err = (q.first_source_head == q.second_source_head) || (q.first_source_head == q.dest_head) ||
                  (q.second_source_head == q.dest_head);
        if (words_needed(len1 + len2) > LEN_W'(q.dest_words)) begin
          chk_err = 1'b1;
        end
      end
      byte_count_op: chk_err = len1 >= LEN_LIMIT;
      tail_extract_op: begin
        chk_err = q.count[15] || LEN_W'(q.count) > len1 ||
                  words_needed(LEN_W'(q.count)) > LEN_W'(q.dest_words);
      end
      default: chk_err = 1'b1;
    endcase
  end

  assign f_out_ready = state == st_copy && !wr_pend;
  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (hold_v),
    .in_data   (hold_b),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready)
  );
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_cond <= 1'b0;
    end else if (scan_strobe) begin
      prev_cond <= cond;
    end
  end
  // Datapath words are always loaded before they are read, so besides q and mem_req only control state is reset.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state       <= st_idle;
      q           <= '0;
      mem_req     <= '0;
      busy        <= 1'b0;
      done        <= 1'b0;
      err_set     <= 1'b0;
      phase       <= '0;
      rd_seg      <= 1'b0;
      hold_v      <= 1'b0;
      have_lo     <= 1'b0;
      wr_pend     <= 1'b0;
    end else begin
      mem_req.rd <= 1'b0;
      mem_req.wr <= 1'b0;
      done       <= 1'b0;
      err_set    <= 1'b0;
      case (state)
        st_idle: begin
          if (start) begin
            q           <= instr;
            busy        <= 1'b1;
            scan_addr   <= {1'b0, instr.first_source_head};
            scan_second <= 1'b0;
            len1        <= '0;
            len2        <= '0;
            phase       <= '0;
            state       <= st_scan;
          end
        end
        st_scan: begin
          // Source is measured word by word before any write, so an error leaves the destination alone.
          case (phase)
            2'd0: begin
              if (scan_addr > {1'b0, q.source_end}) begin
                err_set <= 1'b1;
                state   <= st_done;
              end else begin
                mem_req.rd   <= 1'b1;
                mem_req.addr <= scan_addr[15:0];
                phase        <= 2'd1;
              end
            end
            2'd1: phase <= 2'd2;
            default: begin
              phase <= '0;
              if (pick_byte(mem_rdata, 1'b0) == ZERO_BYTE ||
                  pick_byte(mem_rdata, 1'b1) == ZERO_BYTE) begin
                if (scan_second) begin
                  len2 <= len2 + LEN_W'(pick_byte(mem_rdata, 1'b0) != ZERO_BYTE);
                  state <= st_check;
                end else begin
                  len1 <= len1 + LEN_W'(pick_byte(mem_rdata, 1'b0) != ZERO_BYTE);
                  if (q.op == op_join) begin
                    scan_second <= 1'b1;
                    scan_addr   <= {1'b0, q.second_source_head};
                  end else begin
                    state <= st_check;
                  end
                end
              end else begin
                scan_addr <= scan_addr + 1'b1;
                if (scan_second) begin
                  len2 <= len2 + 2'd2;
                end else begin
                  len1 <= len1 + 2'd2;
                end
              end
            end
          endcase
        end
        st_check: begin
          wr_addr <= q.dest_head;
          have_lo <= 1'b0;
          popped  <= '0;
          if (chk_err) begin
            err_set <= 1'b1;
            state   <= st_done;
          end else if (q.op == byte_count_op) begin
            state <= st_len_wr;
          end else if (q.op == op_join) begin
            out_len <= len1 + len2;
            rd_idx  <= '0;
            rd_base <= (len1 == '0) ? q.second_source_head : q.first_source_head;
            rd_left <= (len1 == '0) ? len2 : len1;
            rd_seg  <= len1 == '0;
            state   <= st_copy;
          end else begin
            out_len <= LEN_W'(q.count);
            rd_base <= q.first_source_head;
            rd_idx  <= len1 - LEN_W'(q.count);
            rd_left <= LEN_W'(q.count);
            rd_seg  <= 1'b1;
            state   <= st_copy;
          end
        end
        st_len_wr: begin
          mem_req.wr    <= 1'b1;
          mem_req.addr  <= q.dest_head;
          mem_req.wdata <= len1[15:0];
          state         <= st_done;
        end
        st_copy: begin
          if (hold_v && f_in_ready) begin
            hold_v <= 1'b0;
          end
          case (phase)
            2'd0: begin
              if (wr_pend) begin
                mem_req.wr    <= 1'b1;
                mem_req.addr  <= wr_addr;
                mem_req.wdata <= wr_word;
                wr_addr       <= wr_addr + 1'b1;
                wr_pend       <= 1'b0;
              end else if (rd_left != '0 && !hold_v) begin
                mem_req.rd   <= 1'b1;
                mem_req.addr <= rd_base + rd_idx[16:1];
                phase        <= 2'd1;
              end
            end
            2'd1: phase <= 2'd2;
            default: begin
              phase  <= '0;
              hold_v <= 1'b1;
              hold_b <= pick_byte(mem_rdata, rd_idx[0]);
              if (rd_left == LEN_W'(1) && !rd_seg) begin
                rd_seg  <= 1'b1;
                rd_base <= q.second_source_head;
                rd_idx  <= '0;
                rd_left <= len2;
              end else begin
                rd_idx  <= rd_idx + 1'b1;
                rd_left <= rd_left - 1'b1;
              end
            end
          endcase
          if (f_out_valid && f_out_ready) begin
            popped <= popped + 1'b1;
            if (have_lo) begin
              wr_word <= {f_out_data, lo_byte};
              wr_pend <= 1'b1;
              have_lo <= 1'b0;
            end else begin
              lo_byte <= f_out_data;
              have_lo <= 1'b1;
            end
          end else if (popped == out_len && !wr_pend && phase == 2'd0) begin
            state <= st_term;
          end
        end
        st_term: begin
          mem_req.wr   <= 1'b1;
          mem_req.addr <= wr_addr;
          // Odd count closes the half-filled word; even count needs a fresh null word.
          mem_req.wdata <= have_lo ? {ZERO_BYTE, lo_byte} : NULL_WORD;
          state <= st_done;
        end
        default: begin
          busy  <= 1'b0;
          done  <= 1'b1;
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      operation_error_flag <= 1'b0;
      error_code_word      <= '0;
    end else begin
      if (err_set) begin
        operation_error_flag <= 1'b1;
        error_code_word      <= ERR_CODE;
      end else if (error_flag_clear) begin
        operation_error_flag <= 1'b0;
      end
    end
  end
  a_port_exclusive: assert property (@(posedge clock) disable iff (sys_rst) !(mem_req.rd && mem_req.wr))
    else $error("read and write together");
  a_error_code_set: assert property (@(posedge clock) disable iff (sys_rst)
    err_set |=> operation_error_flag && error_code_word == ERR_CODE) else $error("error code not stored");
  a_no_write_err: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_check && chk_err) |-> ##1 !mem_req.wr ##1 !mem_req.wr) else $error("write after error");
  a_count_value: assert property (@(posedge clock) disable iff (sys_rst)
    (mem_req.wr && q.op == byte_count_op) |-> mem_req.wdata == len1[15:0] && mem_req.addr == q.dest_head)
    else $error("bad byte count write");
  a_dest_bound: assert property (@(posedge clock) disable iff (sys_rst)
    (mem_req.wr && q.op != byte_count_op) |-> 16'(mem_req.addr - q.dest_head) < q.dest_words)
    else $error("write outside destination");
  a_term_even: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_done && mem_req.wr && q.op != byte_count_op && !have_lo) |-> mem_req.wdata == NULL_WORD)
    else $error("even terminator wrong");
  a_term_odd: assert property (@(posedge clock) disable iff (sys_rst)
    (state == st_done && mem_req.wr && q.op != byte_count_op && have_lo) |->
    mem_req.wdata == {ZERO_BYTE, lo_byte}) else $error("odd terminator wrong");
  a_pulse_once: assert property (@(posedge clock) disable iff (sys_rst)
    (!busy && scan_strobe && cond && instr.pulse && prev_cond) |=> !busy) else $error("pulse op repeated");
endmodule // string_engine

// ---- test/string_mem_model.sv ----
`timescale 1ns/1ps

module string_mem_model
  import string_ops_pkg::*;
(
  input  wire logic                clock,
  input  string_ops_pkg::mem_req_t mem_req,
  output logic [15:0]              mem_rdata
);
  import string_ops_pkg::*;

  logic [15:0] mem [0:255];
  logic [15:0] held = 16'h0000;
  logic [1:0]  age  = 2'h0;

  // Write requests land in the word array on the edge that sees them.
  always @(posedge clock) begin
    if (mem_req.wr) begin
      mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
    if (mem_req.rd) begin
      held <= mem[mem_req.addr[7:0]];
      age  <= 2'h2;
    end else if (age != 2'h0) begin
      age <= age - 2'h1;
    end
  end

  // Read data stands for two cycles and then turns to its inverse, so a late sample is caught.
  assign mem_rdata = (age != 2'h0) ? held : ~held;
endmodule // string_mem_model

// ---- test/byte_string_ops_engine_tb.sv ----
`timescale 1ns/1ps

module byte_string_ops_engine_tb;
  import string_ops_pkg::*;

  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  instr_t      instr = '0;
  logic        scan_strobe = 1'b0;
  logic        cond = 1'b0;
  logic        error_flag_clear = 1'b0;
  mem_req_t    mem_req;
  logic [15:0] mem_rdata;
  logic        busy;
  logic        done;
  logic        operation_error_flag;
  logic [15:0] error_code_word;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          dones = 0;
  int          seed = 32'h0A63;
  int          la;
  int          lb;
  int          n;
  logic [7:0]  sa [0:63];
  logic [7:0]  sb [0:63];
  logic [7:0]  xb [0:127];

  string_engine i_dut (.clock(clock), .sys_rst(sys_rst), .instr(instr), .scan_strobe(scan_strobe),
    .cond(cond), .mem_req(mem_req), .mem_rdata(mem_rdata), .error_flag_clear(error_flag_clear),
    .busy(busy), .done(done), .operation_error_flag(operation_error_flag),
    .error_code_word(error_code_word));

  string_mem_model i_mem (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

  initial begin
    forever #2.5 clock = ~clock;
  end

  function automatic int rnd(input int m);
    rnd = $unsigned($random(seed)) % m;
  endfunction

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (done === 1'b1) begin
      dones++;
    end
    if (cycles == 30000) begin
      failures++;
      $display("ERROR run time expected under 30000 cycles seen 30000");
      summarize();
    end
  end

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Stores a string in the model with its terminator, two bytes a word, first byte low.
  task automatic put_str(input int addr, input int len, input bit sel);
    logic [7:0] c;
    for (int k = 0; k <= len; k++) begin
      c = (k == len) ? ZERO_BYTE : (sel ? sb[k] : sa[k]);
      if (k % 2 == 1) begin
        i_mem.mem[addr + k / 2][15:8] = c;
      end else begin
        i_mem.mem[addr + k / 2] = {8'h00, c};
      end
    end
  endtask

  task automatic fill_dest();
    for (int w = 0; w < 48; w++) begin
      i_mem.mem[96 + w] = 16'hC3C3;
    end
  endtask

  // Expected destination word w of a result of len bytes, terminator and null word included.
  function automatic logic [15:0] exp_word(input int w, input int len);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = (2 * w < len) ? xb[2 * w] : ZERO_BYTE;
    hi = (2 * w + 1 < len) ? xb[2 * w + 1] : ZERO_BYTE;
    return {hi, lo};
  endfunction

  task automatic cmp_str(input int len);
    for (int w = 0; w <= len / 2; w++) begin
      check16("dest word", exp_word(w, len), i_mem.mem[96 + w]);
    end
  endtask

  task automatic cmp_fill();
    for (int w = 0; w < 16; w++) begin
      check16("untouched destination", 16'hC3C3, i_mem.mem[96 + w]);
    end
  endtask

  task automatic run_op(input op_kind_t op, input int s1, input int s2, input int dw, input int se,
                        input int cnt, input bit err);
    int t;
    @(negedge clock);
    instr.op = op;
    instr.pulse = 1'b0;
    instr.first_source_head = 16'(s1);
    instr.second_source_head = 16'(s2);
    instr.dest_head = 16'h0060;
    instr.dest_words = 16'(dw);
    instr.source_end = 16'(se);
    instr.count = 16'(cnt);
    scan_strobe = 1'b1;
    cond = 1'b1;
    @(negedge clock);
    scan_strobe = 1'b0;
    cond = 1'b0;
    check16("busy after start", 16'h0001, {15'h0000, busy});
    t = 0;
    while (done !== 1'b1 && t < 2000) begin
      @(negedge clock);
      t++;
    end
    check16("done pulse", 16'h0001, {15'h0000, done});
    check16("busy at done", 16'h0000, {15'h0000, busy});
    @(negedge clock);
    check16("error flag", {15'h0000, err}, {15'h0000, operation_error_flag});
    if (err) begin
      check16("error code", ERR_CODE, error_code_word);
    end
    error_flag_clear = 1'b1;
    @(negedge clock);
    error_flag_clear = 1'b0;
    @(negedge clock);
    check16("cleared flag", 16'h0000, {15'h0000, operation_error_flag});
  endtask

  task automatic strobe(input logic c);
    @(negedge clock);
    scan_strobe = 1'b1;
    cond = c;
    @(negedge clock);
    scan_strobe = 1'b0;
    repeat (40) @(negedge clock);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    check16("reset code", 16'h0000, error_code_word);
    check16("reset busy", 16'h0000, {15'h0000, busy});
    for (int r = 0; r < 12; r++) begin
      la = (r == 0) ? 0 : rnd(21);
      lb = (r == 3) ? 0 : rnd(21);
      for (int k = 0; k < 21; k++) begin
        sa[k] = 8'(rnd(255) + 1);
        sb[k] = 8'(rnd(255) + 1);
      end
      put_str(16, la, 1'b0);
      put_str(48, lb, 1'b1);
      for (int k = 0; k < la; k++) xb[k] = sa[k];
      for (int k = 0; k < lb; k++) xb[la + k] = sb[k];
      fill_dest();
      run_op(op_join, 16, 48, (la + lb) / 2 + 1, 255, 0, 1'b0);
      cmp_str(la + lb);
      run_op(byte_count_op, 16, 48, 1, 255, 0, 1'b0);
      check16("byte count", 16'(la), i_mem.mem[96]);
      n = (r == 1) ? 0 : ((r == 2) ? la : rnd(la + 1));
      for (int k = 0; k < n; k++) xb[k] = sa[la - n + k];
      fill_dest();
      run_op(tail_extract_op, 16, 48, n / 2 + 1, 255, n, 1'b0);
      cmp_str(n);
    end
    // Faults: each must leave the destination as it was.
    la = 9;
    lb = 4;
    put_str(16, la, 1'b0);
    put_str(48, lb, 1'b1);
    fill_dest();
    run_op(op_join, 16, 48, (la + lb) / 2, 255, 0, 1'b1);
    cmp_fill();
    run_op(op_join, 16, 16, 16, 255, 0, 1'b1);
    cmp_fill();
    run_op(byte_count_op, 16, 48, 1, 19, 0, 1'b1);
    cmp_fill();
    run_op(tail_extract_op, 16, 48, 16, 19, 2, 1'b1);
    run_op(tail_extract_op, 16, 48, 16, 255, 10, 1'b1);
    run_op(tail_extract_op, 16, 48, 16, 255, -1, 1'b1);
    cmp_fill();
    // Nine bytes need five words, so four must be refused and five accepted.
    run_op(tail_extract_op, 16, 48, 4, 255, 9, 1'b1);
    run_op(op_kind_t'(2'd3), 16, 48, 16, 255, 0, 1'b1);
    cmp_fill();
    for (int k = 0; k < 9; k++) xb[k] = sa[k];
    run_op(tail_extract_op, 16, 48, 5, 255, 9, 1'b0);
    cmp_str(9);
    // A pulse variant starts once per rise of its condition, the continuous one on every scan.
    instr.op = byte_count_op;
    instr.pulse = 1'b1;
    instr.dest_words = 16'h0001;
    strobe(1'b0);
    dones = 0;
    for (int k = 0; k < 3; k++) strobe(1'b1);
    check16("pulse runs", 16'h0001, 16'(dones));
    instr.pulse = 1'b0;
    dones = 0;
    for (int k = 0; k < 3; k++) strobe(1'b1);
    check16("continuous runs", 16'h0003, 16'(dones));
    check16("count after scans", 16'h0009, i_mem.mem[96]);
    summarize();
  end
endmodule // byte_string_ops_engine_tb
